// file: pws_consts.svh
// constants for the power and wake sequencer
`ifndef PWS_CONSTS_SVH
`define PWS_CONSTS_SVH
`define PWS_CLK_PERIOD_PS 5000
`define PWS_SETTLE_TIMEOUT_US 200
`define PWS_ADR_CTRL 4'h0
`define PWS_ADR_COUNT 4'h4
`define PWS_ADR_STATUS 4'h8
`define PWS_CTRL_TO_DIS 0
`define PWS_CTRL_COPY_EN 1
`define PWS_CTRL_RET_RAM 2
`define PWS_CTRL_RESET 3'h2
`define PWS_COUNT_RESET 14'h0000
`define PWS_OTP_BASE 13'h0000
`define PWS_RAM_BASE 13'h0000
`endif

// file: pws_pkg.sv
// types for the power and wake sequencer
package pws_pkg;
    typedef enum logic [3:0] {
        ST_BOOST_CHK,
        ST_BANDGAP,
        ST_LDO,
        ST_XTAL,
        ST_HANDOVER,
        ST_MIRROR,
        ST_RUN,
        ST_SLEEP
    } pws_state_e;
    typedef struct packed {
        logic boostCmp;
        logic buckCmp;
        logic bandgapOk;
        logic coreRegOk;
        logic memRegOk;
        logic xtalOk;
        logic wakePin;
    } pws_analog_s;
    typedef struct packed {
        logic bandgapEn;
        logic coreRegEn;
        logic memRegEn;
        logic dcdcEn;
        logic dcdcBoost;
        logic xtalEn;
    } pws_power_s;
    typedef struct packed {
        logic [12:0] otpAddr;
        logic otpRd;
        logic [12:0] ramAddr;
        logic [31:0] ramData;
        logic ramWe;
    } pws_copy_s;
endpackage

// file: pws_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pws_sync #(
    parameter int N = 7
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [N-1:0] async,
    output logic [N-1:0] synced
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] out;
    } pws_sync_s;
    pws_sync_s cur_ff;
    pws_sync_s nxt_cur;
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.s1 = async;
        nxt_cur.s2 = cur_ff.s1;
        nxt_cur.s3 = cur_ff.s2;
        for (int i = 0; i < N; i++)
        begin
            // only the later two stages decide, the first may be metastable
            if (cur_ff.s2[i] == cur_ff.s3[i])
            begin
                nxt_cur.out[i] = cur_ff.s3[i];
            end
        end
    end
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end
    assign synced = cur_ff.out;
endmodule

// file: pws_mirror.sv
// hardware copy engine from program memory into system ram
`timescale 1ns/1ps
`include "pws_consts.svh"
module pws_mirror (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [13:0] wordCount,
    input wire logic otpAck,
    input wire logic [31:0] otpData,
    output pws_pkg::pws_copy_s copy,
    output logic done
);
    typedef struct packed {
        logic busy;
        logic waitRd;
        logic [13:0] left;
        pws_pkg::pws_copy_s copy;
        logic done;
    } pws_mir_s;
    pws_mir_s cur_ff;
    pws_mir_s nxt_cur;
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.copy.ramWe = 1'b0;
        nxt_cur.done = 1'b0;
        if (!cur_ff.busy)
        begin
            if (start)
            begin
                nxt_cur.busy = 1'b1;
                nxt_cur.left = wordCount;
                nxt_cur.copy.otpAddr = `PWS_OTP_BASE;
                nxt_cur.copy.ramAddr = `PWS_RAM_BASE;
            end
        end
        else if (cur_ff.waitRd)
        begin
            if (otpAck)
            begin
                nxt_cur.waitRd = 1'b0;
                nxt_cur.copy.otpRd = 1'b0;
                nxt_cur.copy.ramData = otpData;
                nxt_cur.copy.ramWe = 1'b1;
                nxt_cur.left = cur_ff.left - 14'h0001;
            end
        end
        else if (cur_ff.copy.ramWe)
        begin
            nxt_cur.copy.otpAddr = cur_ff.copy.otpAddr + 13'h0001;
            nxt_cur.copy.ramAddr = cur_ff.copy.ramAddr + 13'h0001;
        end
        else if (cur_ff.left == 14'h0000)
        begin
            nxt_cur.busy = 1'b0;
            nxt_cur.done = 1'b1;
        end
        else
        begin
            nxt_cur.waitRd = 1'b1;
            nxt_cur.copy.otpRd = 1'b1;
        end
    end
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end
    assign copy = cur_ff.copy;
    assign done = cur_ff.done;
endmodule

// file: pws_seq.sv
// power-up and wake sequencer with wishbone control registers
`timescale 1ns/1ps
`include "pws_consts.svh"
module pws_seq #(
    parameter int SETTLE_TIMEOUT_CYC =
        (`PWS_SETTLE_TIMEOUT_US * 1000000) / `PWS_CLK_PERIOD_PS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pws_pkg::pws_analog_s analogIn,
    input wire logic sleepReq,
    output pws_pkg::pws_power_s power,
    output logic cpuRun,
    output logic bootRun,
    output logic coldStart,
    input wire logic otpAck,
    input wire logic [31:0] otpData,
    output pws_pkg::pws_copy_s copy
);
    typedef struct packed {
        pws_pkg::pws_state_e state;
        logic cold;
        logic wasDeep;
        logic timedOut;
        logic [31:0] waitCnt;
        logic mirStart;
        pws_pkg::pws_power_s power;
        logic cpuRun;
        logic bootRun;
        logic [2:0] ctrl;
        logic [13:0] wordCount;
        logic ack;
        logic [31:0] rdata;
    } pws_top_s;

    pws_top_s cur_ff;
    pws_top_s nxt_cur;
    pws_pkg::pws_analog_s ana;
    logic mirDone;
    logic settleOk;
    logic timeUp;
    logic access;

    pws_sync #(
        .N(7)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async(analogIn),
        .synced(ana)
    );

    pws_mirror u_mirror (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(cur_ff.mirStart),
        .wordCount(cur_ff.wordCount),
        .otpAck(otpAck),
        .otpData(otpData),
        .copy(copy),
        .done(mirDone)
    );

    // settle condition for the stage in progress
    always_comb
    begin
        case (cur_ff.state)
            pws_pkg::ST_BANDGAP: settleOk = ana.bandgapOk;
            pws_pkg::ST_LDO: settleOk = ana.coreRegOk & ana.memRegOk;
            pws_pkg::ST_XTAL: settleOk = ana.xtalOk;
            default: settleOk = 1'b1;
        endcase
    end

    // a stuck settle line must not hang the chip unless software asks
    assign timeUp = !cur_ff.ctrl[`PWS_CTRL_TO_DIS]
        && (cur_ff.waitCnt >= 32'(SETTLE_TIMEOUT_CYC - 1));

    assign access = wb_cyc_i && wb_stb_i && !cur_ff.ack;

    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.mirStart = 1'b0;
        nxt_cur.ack = access;
        nxt_cur.rdata = 32'h0000_0000;

        // register bus
        if (access && !wb_we_i)
        begin
            case (wb_adr_i)
                `PWS_ADR_CTRL: nxt_cur.rdata = {29'h0, cur_ff.ctrl};
                `PWS_ADR_COUNT: nxt_cur.rdata = {18'h0, cur_ff.wordCount};
                `PWS_ADR_STATUS: nxt_cur.rdata = {20'h0,
                    cur_ff.power.dcdcBoost, cur_ff.timedOut,
                    cur_ff.wasDeep, cur_ff.cold,
                    4'(cur_ff.state), cur_ff.cpuRun, cur_ff.bootRun,
                    cur_ff.power.dcdcEn, cur_ff.power.xtalEn};
                default: nxt_cur.rdata = 32'h0000_0000;
            endcase
        end
        if (access && wb_we_i)
        begin
            case (wb_adr_i)
                `PWS_ADR_CTRL:
                begin
                    if (wb_sel_i[0])
                    begin
                        nxt_cur.ctrl = wb_dat_i[2:0];
                    end
                end
                `PWS_ADR_COUNT:
                begin
                    // only a power-on reset clears it, so it outlives sleep
                    if (wb_sel_i[0])
                    begin
                        nxt_cur.wordCount[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1])
                    begin
                        nxt_cur.wordCount[13:8] = wb_dat_i[13:8];
                    end
                end
                default:
                begin
                end
            endcase
        end

        // sequencer
        if (settleOk)
        begin
            nxt_cur.waitCnt = 32'h0000_0000;
        end
        else
        begin
            nxt_cur.waitCnt = cur_ff.waitCnt + 32'h0000_0001;
        end

        case (cur_ff.state)
            pws_pkg::ST_BOOST_CHK:
            begin
                nxt_cur.waitCnt = 32'h0000_0000;
                if (ana.boostCmp)
                begin
                    nxt_cur.power.dcdcEn = 1'b1;
                    nxt_cur.power.dcdcBoost = 1'b1;
                end
                nxt_cur.power.bandgapEn = 1'b1;
                nxt_cur.state = pws_pkg::ST_BANDGAP;
            end
            pws_pkg::ST_BANDGAP:
            begin
                if (settleOk || timeUp)
                begin
                    nxt_cur.timedOut = cur_ff.timedOut | !settleOk;
                    nxt_cur.waitCnt = 32'h0000_0000;
                    nxt_cur.power.coreRegEn = 1'b1;
                    nxt_cur.power.memRegEn = 1'b1;
                    nxt_cur.state = pws_pkg::ST_LDO;
                end
            end
            pws_pkg::ST_LDO:
            begin
                if (settleOk || timeUp)
                begin
                    nxt_cur.timedOut = cur_ff.timedOut | !settleOk;
                    nxt_cur.waitCnt = 32'h0000_0000;
                    nxt_cur.power.xtalEn = 1'b1;
                    // second check replaces the first-pass mode setting
                    if (ana.boostCmp)
                    begin
                        nxt_cur.power.dcdcEn = 1'b1;
                        nxt_cur.power.dcdcBoost = 1'b1;
                    end
                    else if (ana.buckCmp)
                    begin
                        nxt_cur.power.dcdcEn = 1'b1;
                        nxt_cur.power.dcdcBoost = 1'b0;
                    end
                    else
                    begin
                        nxt_cur.power.dcdcEn = 1'b0;
                        nxt_cur.power.dcdcBoost = 1'b0;
                    end
                    nxt_cur.state = pws_pkg::ST_XTAL;
                end
            end
            pws_pkg::ST_XTAL:
            begin
                if (settleOk || timeUp)
                begin
                    nxt_cur.timedOut = cur_ff.timedOut | !settleOk;
                    nxt_cur.waitCnt = 32'h0000_0000;
                    nxt_cur.state = pws_pkg::ST_HANDOVER;
                end
            end
            pws_pkg::ST_HANDOVER:
            begin
                if (cur_ff.cold)
                begin
                    // software does its own copy on a cold start
                    nxt_cur.bootRun = 1'b1;
                    nxt_cur.cpuRun = 1'b1;
                    nxt_cur.state = pws_pkg::ST_RUN;
                end
                else if (cur_ff.wasDeep
                    && cur_ff.ctrl[`PWS_CTRL_COPY_EN])
                begin
                    nxt_cur.mirStart = 1'b1;
                    nxt_cur.state = pws_pkg::ST_MIRROR;
                end
                else
                begin
                    nxt_cur.cpuRun = 1'b1;
                    nxt_cur.state = pws_pkg::ST_RUN;
                end
            end
            pws_pkg::ST_MIRROR:
            begin
                nxt_cur.waitCnt = 32'h0000_0000;
                if (mirDone)
                begin
                    nxt_cur.cpuRun = 1'b1;
                    nxt_cur.state = pws_pkg::ST_RUN;
                end
            end
            pws_pkg::ST_RUN:
            begin
                nxt_cur.waitCnt = 32'h0000_0000;
                if (sleepReq)
                begin
                    // analog is switched off in either sleep mode
                    nxt_cur.power = '0;
                    nxt_cur.cpuRun = 1'b0;
                    nxt_cur.bootRun = 1'b0;
                    nxt_cur.cold = 1'b0;
                    nxt_cur.wasDeep = !cur_ff.ctrl[`PWS_CTRL_RET_RAM];
                    nxt_cur.timedOut = 1'b0;
                    nxt_cur.state = pws_pkg::ST_SLEEP;
                end
            end
            pws_pkg::ST_SLEEP:
            begin
                nxt_cur.waitCnt = 32'h0000_0000;
                if (ana.wakePin)
                begin
                    nxt_cur.state = pws_pkg::ST_BOOST_CHK;
                end
            end
            default:
            begin
                nxt_cur.state = pws_pkg::ST_BOOST_CHK;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur_ff <= '0;
            cur_ff.state <= pws_pkg::ST_BOOST_CHK;
            cur_ff.cold <= 1'b1;
            cur_ff.ctrl <= `PWS_CTRL_RESET;
            cur_ff.wordCount <= `PWS_COUNT_RESET;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign wb_dat_o = cur_ff.rdata;
    assign wb_ack_o = cur_ff.ack;
    assign power = cur_ff.power;
    assign cpuRun = cur_ff.cpuRun;
    assign bootRun = cur_ff.bootRun;
    assign coldStart = cur_ff.cold;
endmodule

// file: pws_props.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/1ps
module pws_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire pws_pkg::pws_power_s power,
    input wire logic cpuRun,
    input wire logic bootRun,
    input wire logic coldStart,
    input wire logic otpAck,
    input wire logic [31:0] otpData,
    input wire pws_pkg::pws_copy_s copy
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack wrong");
    a_cold_flag: assert property ($fell(sys_rst) |-> coldStart)
        else $error("cold flag not set");
    a_boot_cold: assert property (bootRun |-> coldStart)
        else $error("boot without cold start");
    a_mirror_hold: assert property (copy.otpRd |-> !cpuRun && !bootRun)
        else $error("cpu runs during mirror");
    a_read_hold: assert property (copy.otpRd && !otpAck |=> copy.otpRd
        && $stable(copy.otpAddr)) else $error("read not held");
    a_copy_word: assert property (copy.otpRd && otpAck |=> copy.ramWe
        && copy.ramData == $past(otpData)
        && copy.ramAddr == $past(copy.otpAddr)) else $error("bad copy");
    a_we_pulse: assert property (copy.ramWe |=> !copy.ramWe)
        else $error("ram write too long");
    a_rail_order: assert property ($rose(power.coreRegEn)
        |-> power.bandgapEn && $rose(power.memRegEn))
        else $error("regulators out of order");
    a_xtal_order: assert property ($rose(power.xtalEn)
        |-> power.coreRegEn && power.memRegEn) else $error("xtal early");
    a_run_settled: assert property ($rose(cpuRun)
        |-> power.xtalEn && power.bandgapEn) else $error("run early");
endmodule

// file: pws_analog_model.sv
// settle flags, comparators and program memory facing the sequencer
`timescale 1ns/1ps
module pws_analog_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire pws_pkg::pws_power_s power,
    input wire pws_pkg::pws_copy_s copy,
    input wire logic [2:0] drive,
    input wire logic hangXtal,
    input wire logic [3:0] settleLat,
    output pws_pkg::pws_analog_s analogIn,
    output logic otpAck,
    output logic [31:0] otpData
);
    logic [3:0] bgC, rgC, xC, rdC;
    function automatic logic [3:0] sat(input logic en, input logic [3:0] c);
        return en ? (c == 4'hf ? c : c + 4'h1) : 4'h0;
    endfunction
    // flags drop with their enable, so every wake settles from scratch
    assign analogIn = {drive[2], drive[1],
        power.bandgapEn && bgC >= settleLat,
        power.coreRegEn && rgC >= settleLat,
        power.memRegEn && rgC >= settleLat,
        power.xtalEn && xC >= settleLat && !hangXtal, drive[0]};
    always @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bgC <= 4'h0;
            rgC <= 4'h0;
            xC <= 4'h0;
            rdC <= 4'h0;
            otpAck <= 1'b0;
            otpData <= 32'h0;
        end
        else
        begin
            bgC <= sat(power.bandgapEn, bgC);
            rgC <= sat(power.coreRegEn && power.memRegEn, rgC);
            xC <= sat(power.xtalEn, xC);
            // idle data toggles so a stale word is never taken as valid
            if (copy.otpRd && !otpAck && rdC >= settleLat)
            begin
                otpAck <= 1'b1;
                otpData <= {3'h5, copy.otpAddr, 3'h3, copy.otpAddr};
                rdC <= 4'h0;
            end
            else
            begin
                otpAck <= 1'b0;
                otpData <= ~otpData;
                rdC <= copy.otpRd ? rdC + 4'h1 : 4'h0;
            end
        end
    end
endmodule

// file: testbench.sv
// self-checking bench for the power and wake sequencer
`timescale 1ns/1ps
module testbench;
    logic clock = 0;
    logic sys_rst = 1;
    logic cyc = 0, stb = 0, we = 0, sleepReq = 0, hang = 0;
    logic [3:0] adr = 0;
    logic [3:0] lat = 4'h3;
    logic [2:0] drv = 3'b100;
    logic [31:0] wdat = 0, rd, rnd = 32'hf8fcf109;
    logic otpAck, cpuRun, bootRun, coldStart, wbAck;
    logic [31:0] otpData, wbDat;
    pws_pkg::pws_analog_s ana;
    pws_pkg::pws_power_s power;
    pws_pkg::pws_copy_s copy;
    logic [44:0] wrQ[$];
    int miscompares = 0, comparisons = 0;
    always #2.5 clock = ~clock;
    pws_seq #(.SETTLE_TIMEOUT_CYC(20)) i_dut (.clock(clock),
        .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wbDat),
        .wb_ack_o(wbAck), .analogIn(ana), .sleepReq(sleepReq),
        .power(power), .cpuRun(cpuRun), .bootRun(bootRun),
        .coldStart(coldStart), .otpAck(otpAck), .otpData(otpData),
        .copy(copy));
    pws_analog_model i_far (.clock(clock), .sys_rst(sys_rst),
        .power(power), .copy(copy), .drive(drv), .hangXtal(hang),
        .settleLat(lat), .analogIn(ana), .otpAck(otpAck),
        .otpData(otpData));
    always @(posedge clock)
        if (copy.ramWe)
            wrQ.push_back({copy.ramAddr, copy.ramData});
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wbAck !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            $display("[FAIL] wb ack expected 1 seen timeout");
        end
        rd = wbDat;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    // every run ends here: mode, boot branch and the mirrored words
    task automatic ran(input logic boot, input int words);
        int i;
        i = 0;
        while (cpuRun !== 1'b1 && i < 4000)
        begin
            @(posedge clock);
            i++;
        end
        check("cpuRun", 32'(cpuRun), 32'h1);
        check("bootRun", 32'(bootRun), 32'(boot));
        check("dcdc", 32'({power.dcdcEn, power.dcdcBoost}),
            32'({drv[2] | drv[1], drv[2]}));
        check("words", 32'(wrQ.size()), 32'(words));
        for (i = 0; i < wrQ.size(); i++)
        begin
            check("addr", 32'(wrQ[i][44:32]), 32'(i));
            check("data", wrQ[i][31:0], {3'h5, 13'(i), 3'h3, 13'(i)});
        end
        $display("test done: boot %0b words %0d", boot, words);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic doWake(input logic [31:0] ctrl, input int words);
        rnd = lfsr(rnd);
        wb(1, 4'h0, ctrl);
        @(posedge clock);
        sleepReq <= 1;
        @(posedge clock);
        sleepReq <= 0;
        drv <= {rnd[1:0], 1'b0};
        lat <= {1'b0, rnd[4:2]};
        @(posedge clock);
        check("sleep power", 32'(power), 32'h0);
        check("sleep cold", 32'(coldStart), 32'h0);
        wrQ.delete();
        drv[0] <= 1;
        repeat (8) @(posedge clock);
        drv[0] <= 0;
        if (hang)
        begin
            repeat (150) @(posedge clock);
            // with the timeout armed the stuck crystal is skipped
            check("unbounded wait", 32'(cpuRun), 32'(!ctrl[0]));
            hang <= 0;
        end
        ran(1'b0, words);
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        sys_rst <= 0;
        wb(0, 4'h0, 0);
        check("ctrl reset", rd, 32'h2);
        wb(1, 4'hc, 32'hffffffff);
        wb(0, 4'hc, 0);
        check("unmapped", rd, 32'h0);
        wb(1, 4'h4, 32'h3);
        wb(0, 4'h4, 0);
        check("count", rd, 32'h3);
        ran(1'b1, 0);
        check("cold", 32'(coldStart), 32'h1);
        doWake(32'h2, 3);
        doWake(32'h2, 3);
        doWake(32'h6, 0);
        doWake(32'h0, 0);
        wb(1, 4'h4, 32'h0);
        doWake(32'h2, 0);
        hang <= 1;
        doWake(32'h2, 0);
        wb(0, 4'h8, 0);
        check("timed out", 32'(rd[10]), 32'h1);
        hang <= 1;
        doWake(32'h3, 0);
        conclude();
    end
    initial
    begin
        repeat (30000) @(posedge clock);
        miscompares++;
        conclude();
    end
endmodule
bind pws_seq pws_props i_props (.clock(clock), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .power(power), .cpuRun(cpuRun), .bootRun(bootRun),
    .coldStart(coldStart), .otpAck(otpAck), .otpData(otpData),
    .copy(copy));
